// *** shared/wwdt_regs.vh ***
// Constants for the windowed watchdog timer
`ifndef WWDT_REGS_VH
`define WWDT_REGS_VH
`define WWDT_CFG_POST_LSB   0
`define WWDT_CFG_POST_MSB   3
`define WWDT_CFG_PRE_BIT    4
`define WWDT_CFG_WD_WINDOW_DISABLE_BIT 6
`define WWDT_CFG_WIDTH      8
`define WWDT_PRE_SHORT      7'h1f
`define WWDT_PRE_LONG       7'h7f
`define WWDT_SYS_CLK_KHZ    100000
`define WWDT_OSC_KHZ        32
`define WWDT_OSC_DIV        (`WWDT_SYS_CLK_KHZ / (2 * `WWDT_OSC_KHZ))
// Last divider state, 2 * OSC_DIV - 1; needs twelve bits
`define WWDT_OSC_LAST       12'hc33
`endif

// *** rtl/wwdt_top.v ***
// Windowed watchdog timer running on a derived low-power RC clock tick
`include "wwdt_regs.vh"
module wwdt_top (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire [7:0] wd_config_word,
  input  wire       wd_force_enable,
  input  wire       soft_enable_set,
  input  wire       soft_enable_clr,
  input  wire       wd_clear_instr,
  input  wire       power_save_instr,
  input  wire       power_save_idle,
  input  wire       clock_switch_done,
  input  wire       timeout_flag_clr,
  input  wire       sleep_flag_clr,
  input  wire       idle_flag_clr,
  output reg        wd_soft_enable,
  output reg        wd_timeout_flag,
  output reg        sleep_flag,
  output reg        idle_flag,
  output reg        in_power_save,
  output reg        wake_pulse,
  output reg        wd_reset_req,
  output reg        low_power_rc_osc_en
);

  // Power states, one-hot; EXIT lasts one cycle and clears the counters
  localparam [2:0] PWR_RUN  = 3'b001;
  localparam [2:0] PWR_DOZE = 3'b010;
  localparam [2:0] PWR_EXIT = 3'b100;

  reg        rstSync1;
  reg        rstSync2;
  reg [11:0] oscDiv;
  reg        oscTick;
  reg [6:0]  preCount;
  reg        preTick;
  reg [14:0] postCount;
  reg [2:0]  pwrState;

  reg [11:0] next_oscDiv;
  reg        next_oscTick;
  reg [6:0]  next_preCount;
  reg        next_preTick;
  reg [14:0] next_postCount;
  reg [2:0]  next_pwrState;
  reg        next_inSave;
  reg        next_wakePulse;
  reg        next_resetReq;
  reg        next_softEnable;
  reg        next_timeoutFlag;
  reg        next_sleepFlag;
  reg        next_idleFlag;

  wire        wdRun;
  wire        preLong;
  wire [3:0]  postSel;
  wire        windowOn;
  wire [6:0]  preLast;
  wire [14:0] postLast;
  wire        dozing;
  wire        enterSave;
  wire        runClear;
  wire        sleepSet;
  wire        idleSet;
  wire        timeout;
  wire        earlyClr;
  wire        clearCnt;

  // Ratio 2**code; counter runs 0 .. ratio-1
  function [14:0] postLimit;
    input [3:0] code;
    begin
      postLimit = ((15'h0001 << code) - 15'h0001);
    end
  endfunction

  // Final quarter starts at three quarters of the period from ratio 4 up, at half for ratio 2; only ratio 1 (code 0) has no early region
  function [14:0] windowStart;
    input [14:0] last;
    begin
      windowStart = last - (last >> 2);
    end
  endfunction

  // Counter sits in its last state
  function atLast;
    input [14:0] count;
    input [14:0] last;
    begin
      atLast = (count == last);
    end
  endfunction

  // Sticky flag; a set in the same cycle as a clear wins
  function stickyNext;
    input cur;
    input set;
    input clr;
    begin
      if (set) begin
        stickyNext = 1'b1;
      end else if (clr) begin
        stickyNext = 1'b0;
      end else begin
        stickyNext = cur;
      end
    end
  endfunction

  assign wdRun     = wd_force_enable | wd_soft_enable;
  assign preLong   = wd_config_word[`WWDT_CFG_PRE_BIT];
  assign postSel   = wd_config_word[`WWDT_CFG_POST_MSB:`WWDT_CFG_POST_LSB];
  assign windowOn  = ~wd_config_word[`WWDT_CFG_WD_WINDOW_DISABLE_BIT];
  assign preLast   = preLong ? `WWDT_PRE_LONG : `WWDT_PRE_SHORT;
  assign postLast  = postLimit(postSel);
  assign dozing    = pwrState[1];
  assign enterSave = power_save_instr & ~dozing;
  assign runClear  = wd_clear_instr & ~dozing;
  assign sleepSet  = enterSave & ~power_save_idle;
  assign idleSet   = enterSave & power_save_idle;
  assign timeout   = wdRun & preTick & atLast(postCount, postLast);
  assign earlyClr  = wdRun & windowOn & runClear & (postCount < windowStart(postLast));
  // A clear instruction while dozing is ignored; the core cannot issue one then
  assign clearCnt  = clock_switch_done | power_save_instr | pwrState[2] | runClear | ~wdRun;

  // Reset release through two flops; the rest of the block uses the synchronised copy
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // Oscillator tick; not restarted by a counter clear, so the first
  // prescaler step after a clear may be up to one tick short
  always @* begin
    next_oscDiv  = oscDiv + 12'h001;
    next_oscTick = 1'b0;
    if (!wdRun) begin
      next_oscDiv = 12'h000;
    end else if (oscDiv == `WWDT_OSC_LAST) begin
      next_oscDiv  = 12'h000;
      next_oscTick = 1'b1;
    end
  end

  // Prescaler: 32 or 128 oscillator ticks per step
  always @* begin
    next_preCount = preCount;
    next_preTick  = 1'b0;
    if (clearCnt) begin
      next_preCount = 7'h00;
    end else if (oscTick) begin
      if (preCount >= preLast) begin
        next_preCount = 7'h00;
        next_preTick  = 1'b1;
      end else begin
        next_preCount = preCount + 7'h01;
      end
    end
  end

  // Postscaler wraps after 2**code prescaler steps
  always @* begin
    next_postCount = postCount;
    if (clearCnt) begin
      next_postCount = 15'h0000;
    end else if (preTick) begin
      if (atLast(postCount, postLast)) begin
        next_postCount = 15'h0000;
      end else begin
        next_postCount = postCount + 15'h0001;
      end
    end
  end

  // Power state; a time-out while dozing wakes instead of resetting
  always @* begin
    next_pwrState  = pwrState;
    next_wakePulse = 1'b0;
    next_resetReq  = earlyClr;
    case (pwrState)
      PWR_RUN: begin
        if (enterSave) begin
          next_pwrState = PWR_DOZE;
        end
        if (timeout) begin
          next_resetReq = 1'b1;
        end
      end
      PWR_DOZE: begin
        if (timeout) begin
          next_pwrState  = PWR_EXIT;
          next_wakePulse = 1'b1;
        end
      end
      PWR_EXIT: begin
        if (enterSave) begin
          next_pwrState = PWR_DOZE;
        end else begin
          next_pwrState = PWR_RUN;
        end
        if (timeout) begin
          next_resetReq = 1'b1;
        end
      end
      default: begin
        next_pwrState = PWR_RUN;
      end
    endcase
    next_inSave = next_pwrState[1];
  end

  // Software-visible flags
  always @* begin
    next_softEnable  = stickyNext(wd_soft_enable, soft_enable_set, soft_enable_clr);
    next_timeoutFlag = stickyNext(wd_timeout_flag, timeout, timeout_flag_clr);
    next_sleepFlag   = stickyNext(sleep_flag, sleepSet, sleep_flag_clr & ~enterSave);
    next_idleFlag    = stickyNext(idle_flag, idleSet, idle_flag_clr & ~enterSave);
  end

  // Oscillator enable follows the run condition one cycle late
  always @(posedge sys_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      low_power_rc_osc_en <= 1'b0;
    end else begin
      low_power_rc_osc_en <= wdRun;
    end
  end

  always @(posedge sys_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      oscDiv  <= 12'h000;
      oscTick <= 1'b0;
    end else begin
      oscDiv  <= next_oscDiv;
      oscTick <= next_oscTick;
    end
  end

  always @(posedge sys_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      preCount  <= 7'h00;
      preTick   <= 1'b0;
      postCount <= 15'h0000;
    end else begin
      preCount  <= next_preCount;
      preTick   <= next_preTick;
      postCount <= next_postCount;
    end
  end

  always @(posedge sys_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      pwrState      <= PWR_RUN;
      in_power_save <= 1'b0;
      wake_pulse    <= 1'b0;
      wd_reset_req  <= 1'b0;
    end else begin
      pwrState      <= next_pwrState;
      in_power_save <= next_inSave;
      wake_pulse    <= next_wakePulse;
      wd_reset_req  <= next_resetReq;
    end
  end

  always @(posedge sys_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      wd_soft_enable  <= 1'b0;
      wd_timeout_flag <= 1'b0;
      sleep_flag      <= 1'b0;
      idle_flag       <= 1'b0;
    end else begin
      wd_soft_enable  <= next_softEnable;
      wd_timeout_flag <= next_timeoutFlag;
      sleep_flag      <= next_sleepFlag;
      idle_flag       <= next_idleFlag;
    end
  end

endmodule

// *** verification/wwdt_monitor.sv ***
// Port checker for the windowed watchdog timer
module wwdt_monitor (
  input logic       sys_clk, rst_n, wd_force_enable, soft_enable_set, soft_enable_clr, wd_clear_instr,
  input logic       power_save_instr, power_save_idle, clock_switch_done, timeout_flag_clr, sleep_flag_clr,
  input logic       idle_flag_clr, wd_soft_enable, wd_timeout_flag, sleep_flag, idle_flag, in_power_save,
  input logic       wake_pulse, wd_reset_req, low_power_rc_osc_en,
  input logic [7:0] wd_config_word
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Five cycles cover the reset synchroniser and the late oscillator enable
  a_force_runs: assert property (wd_force_enable [*5] |-> low_power_rc_osc_en) else $error("osc off");
  a_soft_gate: assert property ((!wd_force_enable && !wd_soft_enable) [*2] |-> !low_power_rc_osc_en)
    else $error("osc on");
  a_soft_set: assert property (soft_enable_set |=> wd_soft_enable) else $error("soft set");
  a_tflag_hold: assert property (wd_timeout_flag && !timeout_flag_clr |=> wd_timeout_flag) else $error("tflag");
  a_sleep_hold: assert property (sleep_flag && !sleep_flag_clr |=> sleep_flag) else $error("sflag");
  a_idle_hold: assert property (idle_flag && !idle_flag_clr |=> idle_flag) else $error("iflag");
  a_wake_cause: assert property (wake_pulse |-> wd_timeout_flag && !in_power_save) else $error("wake");
  a_wake_single: assert property (wake_pulse |=> !wake_pulse) else $error("wake len");
  a_enter_sleep: assert property (power_save_instr && !power_save_idle && !in_power_save |=> in_power_save && sleep_flag)
    else $error("sleep entry");
  a_reset_awake: assert property (wd_reset_req |-> !$past(in_power_save)) else $error("reset in sleep");
  c_wake: cover property (wake_pulse);
  c_soft: cover property (soft_enable_set);
  c_sleep: cover property (power_save_instr);
endmodule
bind wwdt_top wwdt_monitor u_mon (.*);

// *** verification/wwdt_core_model.sv ***
// Core model issuing watchdog and power-save instruction strobes
module wwdt_core_model (
  input  logic       sys_clk,
  output logic [7:0] req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = 8'h00;
  // Drives strobe req[idx] high from one falling edge to the next, with no window judgement
  task automatic issue(input int idx);
    @(negedge sys_clk) req[idx] = 1'b1;
    @(negedge sys_clk) req[idx] = 1'b0;
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the windowed watchdog timer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_n = 0, wd_force_enable = 0, power_save_idle = 0;
  logic [7:0] wd_config_word = 8'h40;
  wire  wd_clear_instr, power_save_instr, soft_enable_set, soft_enable_clr, clock_switch_done, timeout_flag_clr;
  wire  sleep_flag_clr, idle_flag_clr, wd_soft_enable, wd_timeout_flag, sleep_flag, idle_flag, in_power_save;
  wire  wake_pulse, wd_reset_req, low_power_rc_osc_en;
  wire  [7:0] stat = {wd_soft_enable, low_power_rc_osc_en, wd_timeout_flag, sleep_flag, idle_flag, in_power_save,
                      wake_pulse, wd_reset_req};
  int   n_fail = 0, samples_checked = 0, k;
  always #5 sys_clk = ~sys_clk;
  wwdt_top u_dut (.*);
  wwdt_core_model u_core (.sys_clk(sys_clk), .req({idle_flag_clr, sleep_flag_clr, timeout_flag_clr,
    clock_switch_done, soft_enable_clr, soft_enable_set, power_save_instr, wd_clear_instr}));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial begin
    idle(8); rst_n = 1; idle(3);
    check(stat, 8'h00);
    u_core.issue(2); idle(2); check(stat, 8'hc0);
    u_core.issue(3); idle(2); check(stat, 8'h00);
    wd_force_enable = 1; idle(3); check(stat, 8'h40);
    $display("enable test done");
    wd_config_word = 8'h02; u_core.issue(0); check(stat, 8'h41);
    wd_config_word = 8'h40; idle(1);
    $display("window test done");
    u_core.issue(4); u_core.issue(0); u_core.issue(1); idle(1);
    check(stat, 8'h54);
    // Prescaler /32 with ratio 1 needs at least 31 full oscillator ticks
    for (k = 0; k < 105000 && wake_pulse !== 1'b1; k++) @(negedge sys_clk);
    if (k == 105000) begin n_fail++; final_report(); end
    check({7'h00, k > 96844}, 8'h01);
    check(stat, 8'h72);
    idle(4); check(stat, 8'h70);
    u_core.issue(5); u_core.issue(6); idle(1); check(stat, 8'h40);
    $display("sleep wake test done");
    power_save_idle = 1; u_core.issue(1); idle(1); check(stat, 8'h4c);
    u_core.issue(7); idle(1); check(stat, 8'h44);
    rst_n = 0; idle(2); rst_n = 1; idle(3); check(stat, 8'h40);
    $display("idle and reset test done");
    final_report();
  end
endmodule
